// File: prs_consts.svh
`ifndef PRS_CONSTS_SVH
`define PRS_CONSTS_SVH

// register byte offsets
`define PRS_ADDR_W       8
`define PRS_OFS_CTRL     8'h00
`define PRS_OFS_WDT      8'h04
`define PRS_OFS_STATUS   8'h08
`define PRS_OFS_CODE     8'h0C

// control word fields and reset value
`define PRS_CTRL_HOST_STOP  0
`define PRS_CTRL_CONTACT_EN 1
`define PRS_CTRL_ERR_STOP   2
`define PRS_CTRL_IDX_LSB    8
`define PRS_CTRL_IDX_MSB    15
`define PRS_CTRL_RESET      16'h0000

// status word fields
`define PRS_STS_DIAG     0
`define PRS_STS_SELF     1
`define PRS_STS_ST_LSB   4
`define PRS_STS_ST_MSB   6
`define PRS_STS_EXPIRED  8
`define PRS_STS_RSTOP    9
`define PRS_STS_LED      10

// input points X0 .. X8F
`define PRS_NUM_POINTS   144
`define PRS_LAST_POINT   8'h8F

// scan supervision: limit counted in 10 ms steps, 10 .. 2000 ms
`define PRS_WDT_STEP_MS  10
`define PRS_WDT_MIN      8'h01
`define PRS_WDT_MAX      8'hC8
`define PRS_WDT_RESET    8'h14
`define PRS_CLK_HZ       25000000
`define PRS_TICK_CYCLES  (`PRS_CLK_HZ / 1000 * `PRS_WDT_STEP_MS)
`define PRS_TICK_W       18
`define PRS_BLINK_TICKS  8'h19

// error codes; the supervision and diagnosis codes are arbitrary
`define PRS_CODE_BCD     16'h0032
`define PRS_CODE_WDT     16'h0100
`define PRS_CODE_DIAG    16'h0101

// bus responses
`define PRS_RESP_OKAY    2'h0
`define PRS_RESP_SLVERR  2'h2

`endif

// File: prs_pkg.sv
`default_nettype none
package prs_pkg;

   typedef enum logic [2:0] {
      PRS_DIAG     = 3'b000,
      PRS_STOP     = 3'b001,
      PRS_RUN      = 3'b010,
      PRS_STOPPING = 3'b011,
      PRS_ERROR    = 3'b100
   } prs_state_t;

   typedef enum logic [2:0] {
      PRS_REG_CTRL   = 3'b000,
      PRS_REG_WDT    = 3'b001,
      PRS_REG_STATUS = 3'b010,
      PRS_REG_CODE   = 3'b011,
      PRS_REG_NONE   = 3'b111
   } prs_reg_t;

endpackage : prs_pkg
`default_nettype wire

// File: prs_wdt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface prs_wdt_if;
   logic       restart;
   logic       enable;
   logic       fault;
   logic [7:0] limit;
   logic       tick;
   logic       expired;
   logic [7:0] count;

   modport ctl (output restart, output enable, output fault, output limit,
                input tick, input expired, input count);
   modport wdt (input restart, input enable, input fault, input limit,
                output tick, output expired, output count);
endinterface : prs_wdt_if
`default_nettype wire

// File: prs_wdt.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module prs_wdt #(
   parameter int unsigned TICK_CYCLES = `PRS_TICK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   prs_wdt_if.wdt   wif
);
   localparam logic [`PRS_TICK_W-1:0] TICK_LAST =
      `PRS_TICK_W'(TICK_CYCLES - 1);

   logic [`PRS_TICK_W-1:0] div_reg;
   logic                   tick_reg;
   logic [7:0]             count_reg;
   logic                   expired_reg;

   assign wif.tick    = tick_reg;
   assign wif.count   = count_reg;
   assign wif.expired = expired_reg;

   // divider restarts with the scan so a timeout is exactly limit steps
   always_ff @(posedge clk_sys) begin
      if (!rst_n || wif.restart || div_reg == TICK_LAST) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_reg + 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= !wif.restart && div_reg == TICK_LAST;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n || wif.restart || !wif.enable) begin
         count_reg <= '0;
      end else if (tick_reg && count_reg != 8'hFF) begin
         count_reg <= count_reg + 8'h01;
      end
   end

   // a hardware fault trips the timer even across a restart
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         expired_reg <= 1'b0;
      end else if (wif.fault) begin
         expired_reg <= 1'b1;
      end else if (wif.restart || !wif.enable) begin
         expired_reg <= 1'b0;
      end else if (count_reg >= wif.limit) begin
         expired_reg <= 1'b1;
      end
   end

   restart_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wif.restart && !wif.fault |=> count_reg == 8'h00 && !expired_reg)
      else $error("timer not cleared by restart");
   expire_due_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      wif.enable && !wif.restart && count_reg >= wif.limit |=> expired_reg)
      else $error("timer missed its limit");
endmodule : prs_wdt
`default_nettype wire

// File: prs_top.sv
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module prs_top #(
   parameter int unsigned TICK_CYCLES = `PRS_TICK_CYCLES
) (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic [`PRS_ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   input  wire logic [`PRS_ADDR_W-1:0]     s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   input  wire logic                       program_run_enable,
   input  wire logic [`PRS_NUM_POINTS-1:0] input_points,
   input  wire logic                       scan_end,
   input  wire logic                       instr_fail,
   input  wire logic [15:0]                instr_fail_code,
   input  wire logic                       bcd_range_err,
   input  wire logic                       hw_fail,
   output logic                            engine_run,
   output logic                            engine_restart,
   output logic                            engine_skip,
   output logic                            outputs_enable,
   output logic                            run_led,
   output logic                            diag_error_flag,
   output logic                            selfdiag_error_flag,
   output logic [15:0]                     diag_error_code
);
   prs_pkg::prs_state_t state_reg;
   logic [15:0] ctrl_reg;
   logic [7:0]  wdt_limit_reg;
   logic        diag_flag_reg;
   logic        self_flag_reg;
   logic [15:0] code_reg;
   logic        restart_reg;
   logic        skip_reg;
   logic        blink_reg;
   logic [7:0]  blink_cnt_reg;
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [`PRS_ADDR_W-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        do_write;
   logic [31:0] rd_word;
   logic        exec;
   logic        remote_stop;
   logic        enter_run;
   logic        op_err;
   logic        stop_mode;
   logic        wdt_trip;
   logic        fail_stop;
   logic        limit_ok;
   logic        diag_fail;
   logic        wr_ctrl;
   logic        wr_wdt;
   logic        wr_status;
   logic [7:0]  contact_idx;

   prs_wdt_if wif ();

   prs_wdt #(.TICK_CYCLES(TICK_CYCLES)) u_wdt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .wif     (wif)
   );

   function automatic prs_pkg::prs_reg_t reg_sel(
      input logic [`PRS_ADDR_W-1:0] a);
      if (a == `PRS_OFS_CTRL) begin
         return prs_pkg::PRS_REG_CTRL;
      end else if (a == `PRS_OFS_WDT) begin
         return prs_pkg::PRS_REG_WDT;
      end else if (a == `PRS_OFS_STATUS) begin
         return prs_pkg::PRS_REG_STATUS;
      end else if (a == `PRS_OFS_CODE) begin
         return prs_pkg::PRS_REG_CODE;
      end else begin
         return prs_pkg::PRS_REG_NONE;
      end
   endfunction : reg_sel

   // an index beyond the last point reads as an open contact, i.e. run
   function automatic logic point_level(
      input logic [`PRS_NUM_POINTS-1:0] pts,
      input logic [7:0]                 idx);
      if (idx <= `PRS_LAST_POINT) begin
         return pts[idx];
      end else begin
         return 1'b0;
      end
   endfunction : point_level

   // AXI4-Lite write path: address and data taken in either order
   assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
   assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign wr_ctrl   = do_write && reg_sel(aw_addr_reg) == prs_pkg::PRS_REG_CTRL;
   assign wr_wdt    = do_write && reg_sel(aw_addr_reg) == prs_pkg::PRS_REG_WDT;
   assign wr_status = do_write && w_strb_reg[0] &&
                      reg_sel(aw_addr_reg) == prs_pkg::PRS_REG_STATUS;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         aw_hold_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_hold_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
         aw_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         w_hold_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_hold_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
         w_hold_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= `PRS_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= reg_sel(aw_addr_reg) == prs_pkg::PRS_REG_NONE ?
                       `PRS_RESP_SLVERR : `PRS_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // read path
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (reg_sel(s_axi_araddr))
         prs_pkg::PRS_REG_CTRL: rd_word[15:0] = ctrl_reg;
         prs_pkg::PRS_REG_WDT:  rd_word[7:0]  = wdt_limit_reg;
         prs_pkg::PRS_REG_STATUS: begin
            rd_word[`PRS_STS_DIAG]    = diag_flag_reg;
            rd_word[`PRS_STS_SELF]    = self_flag_reg;
            rd_word[`PRS_STS_ST_MSB:`PRS_STS_ST_LSB] = state_reg;
            rd_word[`PRS_STS_EXPIRED] = wif.expired;
            rd_word[`PRS_STS_RSTOP]   = remote_stop;
            rd_word[`PRS_STS_LED]     = run_led;
         end
         prs_pkg::PRS_REG_CODE: rd_word[15:0] = code_reg;
         default:               rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0000_0000;
         rresp_reg  <= `PRS_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_word;
         rresp_reg  <= reg_sel(s_axi_araddr) == prs_pkg::PRS_REG_NONE ?
                       `PRS_RESP_SLVERR : `PRS_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ctrl_reg <= `PRS_CTRL_RESET;
      end else if (wr_ctrl) begin
         if (w_strb_reg[0]) ctrl_reg[7:0]  <= w_data_reg[7:0];
         if (w_strb_reg[1]) ctrl_reg[15:8] <= w_data_reg[15:8];
      end
   end

   // out-of-range limits are refused so the timer never sees zero
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wdt_limit_reg <= `PRS_WDT_RESET;
      end else if (wr_wdt && w_strb_reg[0] &&
                   w_data_reg[7:0] >= `PRS_WDT_MIN &&
                   w_data_reg[7:0] <= `PRS_WDT_MAX) begin
         wdt_limit_reg <= w_data_reg[7:0];
      end
   end

   // run and stop control
   assign contact_idx = ctrl_reg[`PRS_CTRL_IDX_MSB:`PRS_CTRL_IDX_LSB];
   assign remote_stop = ctrl_reg[`PRS_CTRL_HOST_STOP] |
                        (ctrl_reg[`PRS_CTRL_CONTACT_EN] &
                         point_level(input_points, contact_idx));
   assign exec      = state_reg == prs_pkg::PRS_RUN ||
                      state_reg == prs_pkg::PRS_STOPPING;
   assign enter_run = state_reg == prs_pkg::PRS_STOP &&
                      program_run_enable && !remote_stop;
   assign op_err    = exec && (instr_fail || bcd_range_err);
   assign stop_mode = ctrl_reg[`PRS_CTRL_ERR_STOP];
   assign wdt_trip  = exec && wif.expired;
   assign fail_stop = wdt_trip || (op_err && stop_mode);
   assign limit_ok  = wdt_limit_reg >= `PRS_WDT_MIN &&
                      wdt_limit_reg <= `PRS_WDT_MAX;
   assign diag_fail = state_reg == prs_pkg::PRS_DIAG &&
                      (hw_fail || !limit_ok);

   assign wif.restart = enter_run || (exec && scan_end);
   assign wif.enable  = exec;
   assign wif.limit   = wdt_limit_reg;
   assign wif.fault   = hw_fail;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg <= prs_pkg::PRS_DIAG;
      end else begin
         case (state_reg)
            prs_pkg::PRS_DIAG: begin
               state_reg <= diag_fail ? prs_pkg::PRS_ERROR : prs_pkg::PRS_STOP;
            end
            prs_pkg::PRS_STOP: begin
               if (enter_run) state_reg <= prs_pkg::PRS_RUN;
            end
            prs_pkg::PRS_RUN: begin
               if (!program_run_enable) begin
                  state_reg <= prs_pkg::PRS_STOP;
               end else if (fail_stop) begin
                  state_reg <= prs_pkg::PRS_ERROR;
               end else if (remote_stop) begin
                  state_reg <= scan_end ? prs_pkg::PRS_STOP
                                        : prs_pkg::PRS_STOPPING;
               end
            end
            prs_pkg::PRS_STOPPING: begin
               if (!program_run_enable) begin
                  state_reg <= prs_pkg::PRS_STOP;
               end else if (fail_stop) begin
                  state_reg <= prs_pkg::PRS_ERROR;
               end else if (scan_end) begin
                  state_reg <= prs_pkg::PRS_STOP;
               end
            end
            prs_pkg::PRS_ERROR: begin
               // dropping run-enable re-runs the start-up diagnosis
               if (!program_run_enable) state_reg <= prs_pkg::PRS_DIAG;
            end
            default: state_reg <= prs_pkg::PRS_DIAG;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         restart_reg <= 1'b0;
         skip_reg    <= 1'b0;
      end else begin
         restart_reg <= enter_run;
         skip_reg    <= op_err && !stop_mode && !wdt_trip;
      end
   end

   // error flags: a new event wins over a software clear
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         diag_flag_reg <= 1'b0;
      end else begin
         diag_flag_reg <= op_err || (diag_flag_reg &&
            !(wr_status && w_data_reg[`PRS_STS_DIAG]));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         self_flag_reg <= 1'b0;
      end else begin
         self_flag_reg <= wdt_trip || diag_fail || (self_flag_reg &&
            !(wr_status && w_data_reg[`PRS_STS_SELF]));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         code_reg <= 16'h0000;
      end else if (wdt_trip) begin
         code_reg <= `PRS_CODE_WDT;
      end else if (diag_fail) begin
         code_reg <= `PRS_CODE_DIAG;
      end else if (op_err) begin
         code_reg <= bcd_range_err ? `PRS_CODE_BCD : instr_fail_code;
      end
   end

   // lamp starts lit on entry to error, then toggles every blink period
   always_ff @(posedge clk_sys) begin
      if (!rst_n || state_reg != prs_pkg::PRS_ERROR) begin
         blink_cnt_reg <= 8'h00;
         blink_reg     <= 1'b1;
      end else if (wif.tick) begin
         if (blink_cnt_reg == `PRS_BLINK_TICKS - 8'h01) begin
            blink_cnt_reg <= 8'h00;
            blink_reg     <= !blink_reg;
         end else begin
            blink_cnt_reg <= blink_cnt_reg + 8'h01;
         end
      end
   end

   assign engine_run          = exec;
   assign outputs_enable      = exec;
   assign engine_restart      = restart_reg;
   assign engine_skip         = skip_reg;
   assign run_led             = exec || (state_reg == prs_pkg::PRS_ERROR &&
                                         blink_reg);
   assign diag_error_flag     = diag_flag_reg;
   assign selfdiag_error_flag = self_flag_reg;
   assign diag_error_code     = code_reg;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   enable_low_stop_a: assert property (
      exec && !program_run_enable |=> state_reg == prs_pkg::PRS_STOP)
      else $error("engine kept running without run-enable");
   finish_scan_a: assert property (
      state_reg == prs_pkg::PRS_RUN && program_run_enable && remote_stop &&
      !scan_end && !fail_stop |=> engine_run ##0 outputs_enable)
      else $error("remote stop cut the scan short");
   restart_step0_a: assert property (
      state_reg == prs_pkg::PRS_STOP ##1 state_reg == prs_pkg::PRS_RUN
      |-> engine_restart)
      else $error("resume without restart at step 0");
   hold_stop_a: assert property (
      state_reg == prs_pkg::PRS_STOP && remote_stop |=> !exec)
      else $error("left stop while a source still stops");
   stop_outputs_a: assert property (
      state_reg != prs_pkg::PRS_RUN && state_reg != prs_pkg::PRS_STOPPING
      |-> !outputs_enable && !engine_run)
      else $error("outputs live while stopped");
   timeout_error_a: assert property (
      wdt_trip && program_run_enable
      |=> state_reg == prs_pkg::PRS_ERROR && selfdiag_error_flag
      && diag_error_code == `PRS_CODE_WDT && !outputs_enable)
      else $error("scan timeout not handled");
   continue_skip_a: assert property (
      op_err && !stop_mode && !wdt_trip |=> engine_skip && diag_error_flag)
      else $error("continue error did not skip");
   bcd_code_a: assert property (
      state_reg == prs_pkg::PRS_RUN && program_run_enable && !remote_stop &&
      bcd_range_err && !stop_mode && !wif.expired
      |=> diag_error_code == `PRS_CODE_BCD && run_led)
      else $error("range error code or lamp wrong");
   flag_sticky_a: assert property (
      diag_error_flag && !wr_status |=> diag_error_flag)
      else $error("diagnostic flag dropped by itself");

   cover_run_c:     cover property (enter_run ##1 engine_run);
   cover_rstop_c:   cover property (state_reg == prs_pkg::PRS_STOPPING
                                    ##[1:50] state_reg == prs_pkg::PRS_STOP);
   cover_timeout_c: cover property (wdt_trip);
   cover_skip_c:    cover property (engine_skip);
endmodule : prs_top
`default_nettype wire

// File: prs_remote_model.sv
`timescale 1ns/1ps
`default_nettype none
module prs_remote_model (
   input  wire logic         clk_sys,
   input  wire logic [7:0]   idx,
   input  wire logic         stop,
   output logic [143:0]      input_points
);
   logic [15:0] cnt_reg = 16'h0000;
   // unselected points keep moving so a wrong point pick shows up
   always_ff @(posedge clk_sys) begin
      cnt_reg <= cnt_reg + 16'h0001;
   end
   always_comb begin
      input_points      = {9{cnt_reg}};
      input_points[idx] = stop;
   end
endmodule : prs_remote_model
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "prs_consts.svh"
module tb;
   logic         clk_sys = 1'h0, rst_n = 1'h0, c_stop = 1'h0;
   logic [7:0]   s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, idx = 8'h05;
   logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic         s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic         s_axi_rready = 1'h0, program_run_enable = 1'h0;
   logic         scan_end = 1'h0, bcd_range_err = 1'h0, hw_fail = 1'h0;
   logic         instr_fail = 1'h0;
   logic [15:0]  instr_fail_code = 16'h0000;
   logic [31:0]  s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [143:0] input_points;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic         s_axi_rvalid, engine_run, engine_restart, engine_skip;
   logic         outputs_enable, run_led, diag_error_flag, selfdiag_error_flag;
   logic [1:0]   s_axi_bresp, s_axi_rresp, rr;
   logic [15:0]  diag_error_code;
   int           err_count = 0, n_tests = 0, cyc = 0, k;

   prs_top #(.TICK_CYCLES(10)) i_dut (.clk_sys, .rst_n, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .program_run_enable, .input_points, .scan_end, .instr_fail,
      .instr_fail_code, .bcd_range_err, .hw_fail,
      .engine_run, .engine_restart, .engine_skip, .outputs_enable, .run_led,
      .diag_error_flag, .selfdiag_error_flag, .diag_error_code);
   prs_remote_model i_model (.clk_sys, .idx, .stop(c_stop), .input_points);

   initial begin
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end

   task automatic chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("[FAIL] %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
   endtask : wr
   task automatic rdr(input logic [7:0] a);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
   endtask : rdr
   // counts the edges at which a signal is high
   task automatic cnt(ref logic s, input int n);
      k = 0;
      repeat (n) begin
         @(posedge clk_sys);
         k += s;
      end
   endtask : cnt
   task automatic scan();
      scan_end <= 1'h1;
      @(posedge clk_sys);
      scan_end <= 1'h0;
   endtask : scan
   task automatic bcd();
      bcd_range_err <= 1'h1;
      @(posedge clk_sys);
      bcd_range_err <= 1'h0;
   endtask : bcd

   task automatic t_reset();
      rdr(`PRS_OFS_WDT);
      chk("wdt_default", rd, 32'h14);
      chk("run_off", engine_run, 1'h0);
      chk("flags", {diag_error_flag, selfdiag_error_flag}, 2'h0);
      rdr(8'h10);
      chk("unmapped", rr, `PRS_RESP_SLVERR);
   endtask : t_reset
   task automatic t_run();
      program_run_enable <= 1'h1;
      cnt(engine_restart, 6);
      chk("restart", k, 1);
      scan();
      chk("oe_run", outputs_enable, 1'h1);
   endtask : t_run
   task automatic t_stop();
      c_stop <= 1'h1;
      wr(`PRS_OFS_CTRL, 32'h0503);
      cnt(engine_run, 4);
      chk("finish_scan", k, 4);
      scan();
      @(posedge clk_sys);
      chk("stopped", engine_run, 1'h0);
      chk("oe_stop", outputs_enable, 1'h0);
      wr(`PRS_OFS_CTRL, 32'h0502);
      cnt(engine_run, 4);
      chk("hold_stop", k, 0);
      c_stop <= 1'h0;
      cnt(engine_restart, 6);
      chk("rerun", k, 1);
   endtask : t_stop
   task automatic t_err();
      bcd();
      cnt(engine_skip, 3);
      chk("skip", k, 1);
      chk("diag", diag_error_flag, 1'h1);
      chk("code50", diag_error_code, `PRS_CODE_BCD);
      chk("led_on", {run_led, engine_run}, 2'h3);
      instr_fail_code <= 16'h0123;
      instr_fail      <= 1'h1;
      @(posedge clk_sys);
      instr_fail      <= 1'h0;
      cnt(engine_skip, 2);
      chk("instr_skip", k, 1);
      chk("instr_code", diag_error_code, 16'h0123);
      scan();
      wr(`PRS_OFS_CTRL, 32'h0506);
      bcd();
      @(posedge clk_sys);
      chk("err_stop", engine_run, 1'h0);
      chk("sticky", diag_error_flag, 1'h1);
      program_run_enable <= 1'h0;
      repeat (4) @(posedge clk_sys);
      wr(`PRS_OFS_CTRL, 32'h0502);
      program_run_enable <= 1'h1;
      cnt(engine_restart, 6);
      chk("rerun_err", k, 1);
   endtask : t_err
   task automatic t_wdt();
      wr(`PRS_OFS_WDT, 32'hC9);
      wr(`PRS_OFS_WDT, 32'h01);
      scan();
      repeat (5) begin
         repeat (6) @(posedge clk_sys);
         scan();
      end
      chk("silent", selfdiag_error_flag, 1'h0);
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (!selfdiag_error_flag);
      // one 10-cycle step plus four register stages to the flag
      chk("late_at", k, 32'd14);
      chk("code_wdt", diag_error_code, `PRS_CODE_WDT);
      chk("oe_wdt", outputs_enable, 1'h0);
      cnt(run_led, 600);
      chk("blink", k > 100 && k < 500, 1'h1);
      rdr(`PRS_OFS_WDT);
      chk("wdt_set", rd, 32'h01);
      rdr(`PRS_OFS_STATUS);
      chk("status", rd[6:0], 7'h43);
      wr(`PRS_OFS_STATUS, 32'h3);
      chk("cleared", {diag_error_flag, selfdiag_error_flag}, 2'h0);
      hw_fail            <= 1'h1;
      program_run_enable <= 1'h0;
      repeat (4) @(posedge clk_sys);
      chk("hw_code", diag_error_code, `PRS_CODE_DIAG);
      chk("hw_self", selfdiag_error_flag, 1'h1);
   endtask : t_wdt

   task automatic finish_test();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(posedge clk_sys);
      t_reset();
      t_run();
      t_stop();
      t_err();
      t_wdt();
      finish_test();
   end
endmodule : tb
`default_nettype wire
